// ===== fb_master_model.sv
// Behavioural fieldbus master driving the slot memory byte bus.
`timescale 1ns/1ps
module fb_master_model (
  input  wire logic       i_clk,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [8:0] o_addr,
  output logic      [7:0] o_wdata,
  input  wire logic [7:0] i_rdata
);
  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 9'h000;
    o_wdata = 8'h00;
  end

  // Entered at a falling edge; the request is taken at the next rising edge.
  // Released address and data lines show the inverse so stale values cannot pass for data; both strobes drop to zero.
  task automatic xfer(input logic w, input logic [8:0] a,
                      input logic [7:0] d);
    o_wr    = w;
    o_rd    = !w;
    o_addr  = a;
    o_wdata = d;
    @(posedge i_clk);
    @(negedge i_clk);
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask : xfer

  task automatic wr_word(input logic [8:0] a, input logic [15:0] w);
    xfer(1'b1, a, w[15:8]);
    xfer(1'b1, a + 9'h001, w[7:0]);
  endtask : wr_word
endmodule : fb_master_model

// ===== weigh_slot_memory_map.sv
// Fieldbus-facing dual-port slot map for sixteen weighing slaves.
`timescale 1ns/1ps
module weigh_slot_memory_map
  import weigh_slot_pkg::*;
(
  input  wire logic                           i_core_clk,
  input  wire logic                           i_srst,
  input  wire logic                           i_bus_wr,
  input  wire logic                           i_bus_rd,
  input  wire logic [8:0]                     i_bus_addr,
  input  wire logic [7:0]                     i_bus_wdata,
  output logic      [7:0]                     o_bus_rdata,
  input  wire logic                           i_rep_valid,
  input  wire logic [3:0]                     i_rep_slave,
  input  wire weigh_report_t                  i_rep,
  input  wire logic                           i_lim_ack,
  input  wire logic [3:0]                     i_lim_ack_slave,
  output logic                                o_act_valid,
  output action_req_t                         o_act,
  output logic      [NUM_SLAVES-1:0]          o_lim_new
);

  typedef struct packed {
    slot_state_t [NUM_SLAVES-1:0] slot;
    weigh_report_t [NUM_SLAVES-1:0] rep;
    logic [15:0]                  cmd_hi;
    logic [7:0]                   rdata;
    logic                         act_valid;
    action_req_t                  act;
  } core_state_t;

  core_state_t state_q;
  core_state_t state_d;

  logic [3:0]  a_slave;
  logic [4:0]  a_byte;
  logic        a_hit;
  logic [15:0] rd_word;
  logic [15:0] status_rd;
  logic [15:0] g_int;
  logic [15:0] g_frc;
  logic [15:0] n_int;
  logic [15:0] n_frc;
  logic [15:0] new_cmd;

  // Address split: slot index and byte within the slot.
  always_comb begin
    a_slave = '0;
    a_byte  = '0;
    a_hit   = (i_bus_addr < MEM_BYTES);
    for (int n = 0; n < NUM_SLAVES; n++) begin
      if (i_bus_addr >= 9'(n * 20) && i_bus_addr < 9'(n * 20 + 20)) begin
        a_slave = 4'(n);
        a_byte  = 5'(i_bus_addr - 9'(n * 20));
      end
    end
  end

  // Read side view of one slot, with error masking of the weight words.
  always_comb begin
    weigh_report_t r;
    r         = state_q.rep[a_slave];
    // Status bits pass straight through; only bits 12 and 15 are forced.
    status_rd = r.status & STATUS_MASK;
    g_int     = r.gross_int;
    g_frc     = r.gross_frc;
    n_int     = r.net_int;
    n_frc     = r.net_frc;
    status_rd[BIT_DONE1] = state_q.rep[a_slave].status[BIT_DONE1];
    if (r.error_code == ERR_CAL) begin
      g_int = r.cal_int;
      g_frc = r.cal_frc;
    end else if (r.error_code != ERR_NONE) begin
      g_int = '0;
      g_frc = '0;
      n_int = '0;
      n_frc = '0;
    end
    case (a_byte[4:1])
      4'h0:    rd_word = r.error_code;
      4'h1:    rd_word = status_rd;
      4'h2:    rd_word = g_int;
      4'h3:    rd_word = g_frc;
      4'h4:    rd_word = n_int;
      4'h5:    rd_word = n_frc;
      4'h6:    rd_word = state_q.slot[a_slave].lim1_int;
      4'h7:    rd_word = state_q.slot[a_slave].lim1_frc;
      4'h8:    rd_word = state_q.slot[a_slave].lim2_int;
      4'h9:    rd_word = state_q.slot[a_slave].lim2_frc;
      default: rd_word = '0;
    endcase
  end

  // Command bytes merge: high byte latched, low byte completes the word.
  assign new_cmd = {state_q.cmd_hi[7:0], i_bus_wdata};

  always_comb begin
    state_d           = state_q;
    state_d.act_valid = 1'b0;
    if (i_bus_rd) begin
      // Big-endian byte order: even byte is the high half.
      state_d.rdata = !a_hit ? 8'h00 :
                      (a_byte[0] ? rd_word[7:0] : rd_word[15:8]);
    end
    if (i_rep_valid) begin
      state_d.rep[i_rep_slave] = i_rep;
    end
    if (i_lim_ack) begin
      state_d.slot[i_lim_ack_slave].lim_new = 1'b0;
    end
    // Fieldbus writes to bytes 0 to 9 fall through every branch below.
    if (i_bus_wr && a_hit && a_byte >= OFS_COMMAND) begin
      case (a_byte)
        5'h0a: state_d.cmd_hi = {8'h00, i_bus_wdata};
        5'h0b: begin
          if (new_cmd != state_q.slot[a_slave].last_cmd) begin
            state_d.slot[a_slave].last_cmd = new_cmd;
            if (new_cmd != CMD_RESET && new_cmd <= CMD_LAST) begin
              state_d.act_valid  = 1'b1;
              state_d.act.slave  = a_slave;
              state_d.act.action = new_cmd[3:0];
            end
          end
        end
        5'h0c: state_d.slot[a_slave].lim1_int[15:8] = i_bus_wdata;
        5'h0d: state_d.slot[a_slave].lim1_int[7:0]  = i_bus_wdata;
        5'h0e: state_d.slot[a_slave].lim1_frc[15:8] = i_bus_wdata;
        5'h0f: state_d.slot[a_slave].lim1_frc[7:0]  = i_bus_wdata;
        5'h10: state_d.slot[a_slave].lim2_int[15:8] = i_bus_wdata;
        5'h11: state_d.slot[a_slave].lim2_int[7:0]  = i_bus_wdata;
        5'h12: state_d.slot[a_slave].lim2_frc[15:8] = i_bus_wdata;
        5'h13: state_d.slot[a_slave].lim2_frc[7:0]  = i_bus_wdata;
        default: ;
      endcase
      // A new setpoint lets the serial side clear cycle-done flags. Set
      // wins over the acknowledge in the same cycle.
      if (a_byte >= OFS_LIM1_INT) begin
        state_d.slot[a_slave].lim_new = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_q <= '0;
      for (int n = 0; n < NUM_SLAVES; n++) begin
        state_q.slot[n].last_cmd <= CMD_RESET;
        state_q.slot[n].lim1_int <= LIM_RESET;
        state_q.slot[n].lim1_frc <= LIM_RESET;
        state_q.slot[n].lim2_int <= LIM_RESET;
        state_q.slot[n].lim2_frc <= LIM_RESET;
      end
    end else begin
      state_q <= state_d;
    end
  end

  assign o_bus_rdata = state_q.rdata;
  assign o_act_valid = state_q.act_valid;
  assign o_act       = state_q.act;

  genvar g;
  generate
    for (g = 0; g < NUM_SLAVES; g++) begin : g_lim
      assign o_lim_new[g] = state_q.slot[g].lim_new;
    end
  endgenerate

  // Checks.
  a_cmd_fires: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_bus_wr && a_hit && a_byte == 5'h0b && new_cmd >= 16'h0001
     && new_cmd <= 16'h000c && new_cmd != state_q.slot[a_slave].last_cmd)
    |=> o_act_valid && o_act.action == $past(new_cmd[3:0]))
    else $error("Changed command did not fire.");

  a_cmd_repeat: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_bus_wr && a_byte == 5'h0b
     && new_cmd == state_q.slot[a_slave].last_cmd) |=> !o_act_valid)
    else $error("Repeated command fired.");

  a_cmd_none: assert property (@(posedge i_core_clk) disable iff (i_srst)
    o_act_valid |-> o_act.action != 4'h0 && o_act.action <= 4'hc)
    else $error("No-action command forwarded.");

  a_low_ignored: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_bus_wr && a_byte < OFS_COMMAND) |=> !o_act_valid
    && $stable(o_lim_new))
    else $error("Write to unused bytes had an effect.");

  a_err_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && a_hit && a_byte >= OFS_GROSS_INT && a_byte < OFS_LIM1_INT
     && state_q.rep[a_slave].error_code != ERR_NONE
     && state_q.rep[a_slave].error_code != ERR_CAL && !i_rep_valid)
    |=> o_bus_rdata == 8'h00)
    else $error("Weight not zeroed on error.");

  a_bit15_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && a_hit && a_byte == 5'h02) |=> !o_bus_rdata[7])
    else $error("Status bit 15 read as one.");

  a_lim_new: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_bus_wr && a_hit && a_byte >= OFS_LIM1_INT)
    |=> o_lim_new[$past(a_slave)])
    else $error("New setpoint not flagged.");

  a_unmapped: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && !a_hit) |=> o_bus_rdata == 8'h00)
    else $error("Unmapped read not zero.");

  // Read path checks. Each read answers from the state seen at the strobe,
  // so the expected byte is taken one cycle back.

  a_bit12_zero: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && a_hit && a_byte == 5'h02)
    |=> !o_bus_rdata[4])
    else $error("Status bit 12 read as one.");

  a_status_high: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && a_hit && a_byte == 5'h02)
    |=> o_bus_rdata == $past(state_q.rep[a_slave].status[15:8]
                             & STATUS_MASK[15:8]))
    else $error("Status high byte wrong.");

  a_status_low: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && a_hit && a_byte == 5'h03)
    |=> o_bus_rdata == $past(state_q.rep[a_slave].status[7:0]))
    else $error("Status low byte wrong.");

  a_err_high: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && a_hit && a_byte == 5'h00)
    |=> o_bus_rdata == $past(state_q.rep[a_slave].error_code[15:8]))
    else $error("Error code high byte wrong.");

  a_err_low: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && a_hit && a_byte == 5'h01)
    |=> o_bus_rdata == $past(state_q.rep[a_slave].error_code[7:0]))
    else $error("Error code low byte wrong.");

  a_cal_gross: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && a_hit && a_byte == 5'h04
     && state_q.rep[a_slave].error_code == ERR_CAL)
    |=> o_bus_rdata == $past(state_q.rep[a_slave].cal_int[15:8]))
    else $error("Calibration value not shown as gross.");

  a_cal_frac: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && a_hit && a_byte == 5'h07
     && state_q.rep[a_slave].error_code == ERR_CAL)
    |=> o_bus_rdata == $past(state_q.rep[a_slave].cal_frc[7:0]))
    else $error("Calibration fraction not shown as gross.");

  a_cal_net: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && a_hit && a_byte == 5'h08
     && state_q.rep[a_slave].error_code == ERR_CAL)
    |=> o_bus_rdata == $past(state_q.rep[a_slave].net_int[15:8]))
    else $error("Net weight lost during calibration.");

  a_gross_valid: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && a_hit && a_byte == 5'h04
     && state_q.rep[a_slave].error_code == ERR_NONE)
    |=> o_bus_rdata == $past(state_q.rep[a_slave].gross_int[15:8]))
    else $error("Gross integer high byte wrong.");

  a_gross_frac: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && a_hit && a_byte == 5'h06
     && state_q.rep[a_slave].error_code == ERR_NONE)
    |=> o_bus_rdata == $past(state_q.rep[a_slave].gross_frc[15:8]))
    else $error("Gross fraction high byte wrong.");

  a_net_valid: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && a_hit && a_byte == 5'h09
     && state_q.rep[a_slave].error_code == ERR_NONE)
    |=> o_bus_rdata == $past(state_q.rep[a_slave].net_int[7:0]))
    else $error("Net integer low byte wrong.");

  a_lim1_echo: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && a_hit && a_byte == 5'h0c)
    |=> o_bus_rdata == $past(state_q.slot[a_slave].lim1_int[15:8]))
    else $error("Setpoint 1 echo wrong.");

  a_lim2_echo: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_rd && a_hit && a_byte == 5'h13)
    |=> o_bus_rdata == $past(state_q.slot[a_slave].lim2_frc[7:0]))
    else $error("Setpoint 2 echo wrong.");

  a_rdata_hold: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    !i_bus_rd |=> $stable(o_bus_rdata))
    else $error("Read data changed without a read.");

  // Write path checks.

  a_lim_store: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_wr && a_hit && a_byte == 5'h0d)
    |=> state_q.slot[$past(a_slave)].lim1_int[7:0] == $past(i_bus_wdata))
    else $error("Setpoint byte not stored.");

  a_last_cmd: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_wr && a_hit && a_byte == 5'h0b)
    |=> state_q.slot[$past(a_slave)].last_cmd == $past(new_cmd))
    else $error("Last command not recorded.");

  a_cmd_latch: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_wr && a_hit && a_byte == 5'h0a)
    |=> state_q.cmd_hi[7:0] == $past(i_bus_wdata))
    else $error("Command high byte not latched.");

  a_act_slave: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_wr && a_hit && a_byte == 5'h0b && new_cmd != CMD_RESET
     && new_cmd <= CMD_LAST && new_cmd != state_q.slot[a_slave].last_cmd)
    |=> o_act.slave == $past(a_slave))
    else $error("Action sent to the wrong slave.");

  a_over_last: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_wr && a_hit && a_byte == 5'h0b && new_cmd > CMD_LAST)
    |=> !o_act_valid)
    else $error("Out-of-range command fired.");

  a_pulse_once: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (o_act_valid && !(i_bus_wr && a_byte == 5'h0b))
    |=> !o_act_valid)
    else $error("Action pulse stretched.");

  a_ack_clears: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_lim_ack && !(i_bus_wr && a_hit && a_byte >= OFS_LIM1_INT
                    && a_slave == i_lim_ack_slave))
    |=> !o_lim_new[$past(i_lim_ack_slave)])
    else $error("Setpoint flag not cleared by acknowledge.");

  a_unmapped_wr: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (i_bus_wr && !a_hit && !i_lim_ack)
    |=> !o_act_valid && $stable(o_lim_new))
    else $error("Unmapped write had an effect.");

  a_rep_load: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    i_rep_valid
    |=> state_q.rep[$past(i_rep_slave)] == $past(i_rep))
    else $error("Report not stored.");

  // Reset is checked without the disable, since it is the subject here.
  a_reset_quiet: assert property (
    @(posedge i_core_clk)
    i_srst
    |=> !o_act_valid && o_lim_new == '0 && o_bus_rdata == 8'h00)
    else $error("Outputs not cleared by reset.");

  c_repeat: cover property (@(posedge i_core_clk)
    i_bus_wr && a_hit && a_byte == 5'h0b
    && new_cmd == state_q.slot[a_slave].last_cmd);
  c_action: cover property (@(posedge i_core_clk) o_act_valid);
  c_cal: cover property (@(posedge i_core_clk)
    i_rep_valid && i_rep.error_code == ERR_CAL);
  c_lim_ack: cover property (@(posedge i_core_clk)
    i_lim_ack && o_lim_new[i_lim_ack_slave]);

endmodule : weigh_slot_memory_map

// ===== weigh_slot_memory_map_tb_top.sv
// Self-checking testbench of the weigh slot memory map.
`timescale 1ns/1ps
module weigh_slot_memory_map_tb_top;
  import weigh_slot_pkg::*;
  logic                  clk;
  logic                  srst;
  logic                  wr;
  logic                  rd;
  logic [8:0]            addr;
  logic [7:0]            wdata;
  logic [7:0]            rdata;
  logic                  rep_valid;
  logic [3:0]            rep_slave;
  weigh_report_t         rep;
  logic                  lim_ack;
  logic [3:0]            lim_ack_slave;
  logic                  act_valid;
  action_req_t           act;
  logic [NUM_SLAVES-1:0] lim_new;
  int                    errors;
  int                    total_checks;
  int                    cycles;

  weigh_slot_memory_map dut (.i_core_clk(clk), .i_srst(srst),
    .i_bus_wr(wr), .i_bus_rd(rd), .i_bus_addr(addr),
    .i_bus_wdata(wdata), .o_bus_rdata(rdata), .i_rep_valid(rep_valid),
    .i_rep_slave(rep_slave), .i_rep(rep), .i_lim_ack(lim_ack),
    .i_lim_ack_slave(lim_ack_slave), .o_act_valid(act_valid),
    .o_act(act), .o_lim_new(lim_new));

  fb_master_model fb (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata), .i_rdata(rdata));

  always #2.5 clk = ~clk;

  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic rd_chk(input logic [8:0] a, input logic [15:0] exp);
    logic [15:0] w;
    fb.xfer(1'b0, a, 8'h00);
    w[15:8] = rdata;
    fb.xfer(1'b0, a + 9'h001, 8'h00);
    w[7:0] = rdata;
    cmp(w, exp);
  endtask : rd_chk

  task automatic load(input logic [3:0] s, input weigh_report_t r);
    rep_slave = s;
    rep       = r;
    rep_valid = 1'b1;
    @(negedge clk);
    rep_valid = 1'b0;
  endtask : load

  // Writes a command to slave s and checks the one-cycle action pulse.
  task automatic cmd(input logic [3:0] s, input logic [15:0] v,
                     input logic fire);
    fb.wr_word(9'(20 * s + 10), v);
    cmp({15'h0000, act_valid}, {15'h0000, fire});
    if (fire)
      cmp({8'h00, act}, {8'h00, s, v[3:0]});
    @(negedge clk);
    cmp({15'h0000, act_valid}, 16'h0000);
  endtask : cmd

  task automatic t_reset();
    for (int i = 0; i < 20; i += 2)
      rd_chk(9'(i), 16'h0000);
    cmp(lim_new, 16'h0000);
  endtask : t_reset

  task automatic t_report();
    weigh_report_t r;
    r = {ERR_NONE, 16'hffff, 16'h007b, 16'h01f4, 16'hff85, 16'hfe70,
         16'h1111, 16'h2222};
    load(4'h1, r);
    rd_chk(9'd20, 16'h0000);
    rd_chk(9'd22, STATUS_MASK);
    rd_chk(9'd24, 16'h007b);
    rd_chk(9'd26, 16'h01f4);
    rd_chk(9'd28, 16'hff85);
    rd_chk(9'd30, 16'hfe70);
    r.error_code = ERR_CAL;
    load(4'h1, r);
    rd_chk(9'd20, 16'h0013);
    rd_chk(9'd24, 16'h1111);
    rd_chk(9'd26, 16'h2222);
    r.error_code = ERR_UNDER;
    load(4'h1, r);
    rd_chk(9'd20, 16'h0010);
    for (int i = 24; i < 32; i += 2)
      rd_chk(9'(i), 16'h0000);
  endtask : t_report

  task automatic t_cmd();
    for (int v = 1; v <= 12; v++)
      cmd(4'hf, 16'(v), 1'b1);
    cmd(4'hf, 16'h000c, 1'b0);
    cmd(4'hf, 16'h0000, 1'b0);
    cmd(4'hf, 16'h000c, 1'b1);
    cmd(4'hf, 16'h000d, 1'b0);
    cmd(4'hf, 16'hffff, 1'b0);
    cmd(4'hf, 16'h0105, 1'b0);
    cmd(4'hf, 16'h0005, 1'b1);
    cmd(4'h0, 16'h0005, 1'b1);
  endtask : t_cmd

  task automatic t_limit();
    fb.wr_word(9'd72, 16'h1234);
    fb.wr_word(9'd74, 16'h01f4);
    fb.wr_word(9'd76, 16'hff85);
    fb.wr_word(9'd78, 16'hfe70);
    rd_chk(9'd72, 16'h1234);
    rd_chk(9'd74, 16'h01f4);
    rd_chk(9'd76, 16'hff85);
    rd_chk(9'd78, 16'hfe70);
    cmp(lim_new, 16'h0008);
    lim_ack_slave = 4'h3;
    lim_ack       = 1'b1;
    @(negedge clk);
    lim_ack = 1'b0;
    cmp(lim_new, 16'h0000);
    fb.wr_word(9'd64, 16'haa55);
    rd_chk(9'd64, 16'h0000);
    cmp(lim_new, 16'h0000);
    fb.wr_word(9'd320, 16'h5a5a);
    rd_chk(9'd320, 16'h0000);
    fb.wr_word(9'd318, 16'hbeef);
    rd_chk(9'd318, 16'hbeef);
    cmp(lim_new, 16'h8000);
  endtask : t_limit

  initial begin
    clk           = 1'b0;
    srst          = 1'b1;
    rep_valid     = 1'b0;
    rep_slave     = 4'h0;
    rep           = '0;
    lim_ack       = 1'b0;
    lim_ack_slave = 4'h0;
    errors        = 0;
    total_checks  = 0;
    cycles        = 0;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_report();
    t_cmd();
    t_limit();
    wrap_up();
  end
endmodule : weigh_slot_memory_map_tb_top

// ===== weigh_slot_pkg.sv
// Package holding the slot map, codes and carrier types of the weigh slot.
// Contract
// - Sixteen slaves, 20-byte slot each, slave n at byte 20*n.
// - Fieldbus writes to slot bytes 0 to 9 are ignored.
// - Read side: error, status, gross, net, setpoint echoes at fixed bytes.
// - Commands 1 to 6 switch relay 1, relay 2 or both on or off.
// - Commands 7 to 12: tare, zero, gross, net, normal, calibration output.
// - Command 0 and 13 and above do nothing and forward nothing.
// - An action fires only when the command word changes value.
// - Status word returned at bytes 2-3, bit 15 most significant.
// - Status bits 0-5 and 8-11 are meaningful only with error code zero.
// - Bits 0-5: gross neg, net neg, motion, zero, net mode, cal resistor.
// - Bit 6 overload, bit 7 overrange, bit 12 unused, bit 15 reads zero.
// - Bits 8-9 relays active, 10-11 cycle done, 13-14 good zero gross/net.
// - Cycle-done clears only with relay inactive and a new setpoint entered.
// - Error code in bytes 0-1, zero means valid weight.
// - During shunt calibration report code 19, calibration value as gross.
// - Any other nonzero error forces weight bytes 4 to 11 to zero.
// - Error codes 10-14 faults, 16 under, 17 over, 18 too high, 255 comms.
// - Weight is integer word then fraction times 1000, both signed.
// - Integer word stays within -32768 to +32767.
package weigh_slot_pkg;

  localparam int          NUM_SLAVES    = 16;
  localparam logic [8:0]  SLOT_BYTES    = 9'h014;
  localparam logic [8:0]  MEM_BYTES     = 9'h140;
  localparam logic [4:0]  OFS_ERROR     = 5'h00;
  localparam logic [4:0]  OFS_STATUS    = 5'h02;
  localparam logic [4:0]  OFS_GROSS_INT = 5'h04;
  localparam logic [4:0]  OFS_GROSS_FRC = 5'h06;
  localparam logic [4:0]  OFS_NET_INT   = 5'h08;
  localparam logic [4:0]  OFS_NET_FRC   = 5'h0a;
  localparam logic [4:0]  OFS_COMMAND   = 5'h0a;
  localparam logic [4:0]  OFS_LIM1_INT  = 5'h0c;
  localparam logic [4:0]  OFS_LIM1_FRC  = 5'h0e;
  localparam logic [4:0]  OFS_LIM2_INT  = 5'h10;
  localparam logic [4:0]  OFS_LIM2_FRC  = 5'h12;
  localparam logic [15:0] CMD_RESET     = 16'h0000;
  localparam logic [15:0] LIM_RESET     = 16'h0000;
  localparam logic [15:0] CMD_LAST      = 16'h000c;
  localparam logic [15:0] ERR_NONE      = 16'h0000;
  localparam logic [15:0] ERR_UNDER     = 16'h0010;
  localparam logic [15:0] ERR_OVER      = 16'h0011;
  localparam logic [15:0] ERR_HIGH      = 16'h0012;
  localparam logic [15:0] ERR_CAL       = 16'h0013;
  localparam logic [15:0] ERR_COMMS     = 16'h00ff;
  localparam logic [15:0] STATUS_MASK   = 16'h6fff;

  localparam int BIT_GROSS_NEG = 0;
  localparam int BIT_NET_NEG   = 1;
  localparam int BIT_MOTION    = 2;
  localparam int BIT_ZERO_CUR  = 3;
  localparam int BIT_NET_MODE  = 4;
  localparam int BIT_CAL_RES   = 5;
  localparam int BIT_OVERLOAD  = 6;
  localparam int BIT_OVERRANGE = 7;
  localparam int BIT_RELAY1    = 8;
  localparam int BIT_RELAY2    = 9;
  localparam int BIT_DONE1     = 10;
  localparam int BIT_DONE2     = 11;
  localparam int BIT_ZERO_GRS  = 13;
  localparam int BIT_ZERO_NET  = 14;

  // Measurement report from the serial side for one slave.
  typedef struct packed {
    logic [15:0] error_code;
    logic [15:0] status;
    logic [15:0] gross_int;
    logic [15:0] gross_frc;
    logic [15:0] net_int;
    logic [15:0] net_frc;
    logic [15:0] cal_int;
    logic [15:0] cal_frc;
  } weigh_report_t;

  // One action forwarded to the serial side.
  typedef struct packed {
    logic [3:0] slave;
    logic [3:0] action;
  } action_req_t;

  typedef struct packed {
    logic [15:0] last_cmd;
    logic [15:0] lim1_int;
    logic [15:0] lim1_frc;
    logic [15:0] lim2_int;
    logic [15:0] lim2_frc;
    logic        lim_new;
  } slot_state_t;

endpackage : weigh_slot_pkg
